// ===== design/crc_top.sv
// Reflectometry control, pulse launch and reflection monitor
// Notes on behaviour
// - Enable bit hands both line drivers over
// - Send bit launches pulse and starts monitor
// - Bit 14 picks slow or fast driver
// - Width field gives zero to seven clocks
// - Zero width sends no pulse
// - Bit 13 picks pair carrying the pulse
// - Bit 7 tracks maxima or minima
// - Bit 12 picks pair the monitor samples
// - Window register bounds sampled clock indices inclusively
// - Window resets to start 0, stop 255
// - Window indices count sample clocks
// - Capture extreme value and threshold crossing
// - Record first time of extreme and crossing
// - Peak and threshold results read at 18h/19h
// - Time counter starts when pulse launches
// - Zero width still starts the monitor
// - Fast pulses alternate polarity each send
`timescale 1ns/1ps
module crc_top
   import crc_pkg::*;
#(
   parameter int SAMPLE_W = 8
)
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [4:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   input wire logic [SAMPLE_W-1:0] adc_tx_pair,
   input wire logic [SAMPLE_W-1:0] adc_rx_pair,
   input wire logic [SAMPLE_W-1:0] threshold_level,
   output logic reflect_owns_drivers,
   output logic slow_line_driver_pulse,
   output logic fast_line_driver_pulse,
   output logic fast_pulse_negative,
   output logic pulse_on_rx_pair,
   output logic monitor_busy
);
   // ----------------------------------------
   // Register writes
   // ----------------------------------------
   logic [15:0] ctrl_q;
   logic [15:0] win_q;
   logic send_req;
   crc_state_t state_q;
   logic [7:0] time_q;
   logic [2:0] pulse_cnt_q;
   logic src_fast_q;
   logic neg_q;
   logic min_mode_q;
   logic mon_rx_q;
   logic [7:0] peak_val_q;
   logic [7:0] peak_time_q;
   logic peak_seen_q;
   logic [7:0] thr_val_q;
   logic [7:0] thr_time_q;
   logic thr_seen_q;
   logic [SAMPLE_W-1:0] sample;
   logic in_window;
   logic better;
   logic crossed;

   assign send_req = reg_wr && (reg_addr == ADDR_CONTROL) && reg_wdata[CTL_SEND]
      && reg_wdata[CTL_ENABLE];

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         ctrl_q <= CTL_RESET;
      end
      else if (reg_wr && reg_addr == ADDR_CONTROL)
      begin
         ctrl_q <= reg_wdata & CTL_WRITE_MASK & ~(16'h0001 << CTL_SEND);
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         win_q <= WIN_RESET;
      end
      else if (reg_wr && reg_addr == ADDR_WINDOW)
      begin
         win_q <= reg_wdata;
      end
   end

   // ----------------------------------------
   // Sequencer and time counter
   // ----------------------------------------
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         state_q <= ST_IDLE;
         time_q <= TIME_FIRST;
      end
      else if (send_req)
      begin
         state_q <= ST_RUN;
         time_q <= TIME_FIRST;
      end
      else
      begin
         case (state_q)
            ST_RUN:
            begin
               if (time_q == TIME_LAST)
               begin
                  state_q <= ST_IDLE;
               end
               else
               begin
                  time_q <= time_q + 8'h01;
               end
            end
            default:
            begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Pulse generator
   // ----------------------------------------
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         pulse_cnt_q <= WIDTH_NONE;
         src_fast_q <= 1'b0;
         neg_q <= 1'b0;
      end
      else if (send_req)
      begin
         pulse_cnt_q <= reg_wdata[CTL_WIDTH_HI:CTL_WIDTH_LO];
         src_fast_q <= reg_wdata[CTL_FAST_SRC];
         if (reg_wdata[CTL_FAST_SRC] && reg_wdata[CTL_WIDTH_HI:CTL_WIDTH_LO] != WIDTH_NONE)
         begin
            neg_q <= ~neg_q;
         end
      end
      else if (pulse_cnt_q != WIDTH_NONE)
      begin
         pulse_cnt_q <= pulse_cnt_q - WIDTH_ONE;
      end
   end

   assign reflect_owns_drivers = ctrl_q[CTL_ENABLE];
   assign slow_line_driver_pulse = ctrl_q[CTL_ENABLE] && !src_fast_q
      && pulse_cnt_q != WIDTH_NONE;
   assign fast_line_driver_pulse = ctrl_q[CTL_ENABLE] && src_fast_q
      && pulse_cnt_q != WIDTH_NONE;
   assign fast_pulse_negative = neg_q;
   assign pulse_on_rx_pair = ctrl_q[CTL_TX_ON_RX];
   assign monitor_busy = (state_q == ST_RUN);

   // ----------------------------------------
   // Reflection monitor
   // ----------------------------------------
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         min_mode_q <= 1'b0;
         mon_rx_q <= 1'b0;
      end
      else if (send_req)
      begin
         min_mode_q <= reg_wdata[CTL_MIN_MODE];
         mon_rx_q <= reg_wdata[CTL_MON_ON_RX];
      end
   end

   assign sample = mon_rx_q ? adc_rx_pair : adc_tx_pair;
   assign in_window = (state_q == ST_RUN) && (time_q >= win_q[15:8])
      && (time_q <= win_q[7:0]);
   assign better = !peak_seen_q || (min_mode_q
      ? ($signed(sample) < $signed(peak_val_q))
      : ($signed(sample) > $signed(peak_val_q)));
   assign crossed = min_mode_q ? ($signed(sample) < $signed(threshold_level))
      : ($signed(sample) > $signed(threshold_level));

   always_ff @(posedge clock)
   begin
      if (!rst_n || send_req)
      begin
         peak_val_q <= TIME_FIRST;
         peak_time_q <= TIME_FIRST;
         peak_seen_q <= 1'b0;
      end
      else if (in_window && better)
      begin
         peak_val_q <= sample[7:0];
         peak_time_q <= time_q;
         peak_seen_q <= 1'b1;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n || send_req)
      begin
         thr_val_q <= TIME_FIRST;
         thr_time_q <= TIME_FIRST;
         thr_seen_q <= 1'b0;
      end
      else if (in_window && crossed && !thr_seen_q)
      begin
         thr_val_q <= sample[7:0];
         thr_time_q <= time_q;
         thr_seen_q <= 1'b1;
      end
   end

   // ----------------------------------------
   // Register reads
   // ----------------------------------------
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         reg_rdata <= CTL_RESET;
      end
      else if (reg_rd)
      begin
         case (reg_addr)
            ADDR_CONTROL: reg_rdata <= ctrl_q;
            ADDR_WINDOW: reg_rdata <= win_q;
            ADDR_PEAK: reg_rdata <= {peak_time_q, peak_val_q};
            ADDR_THRESHOLD: reg_rdata <= {thr_time_q, thr_val_q};
            default: reg_rdata <= CTL_RESET;
         endcase
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   chk_drivers_owned: assert property (
      (slow_line_driver_pulse || fast_line_driver_pulse) |-> reflect_owns_drivers)
      else $error("pulse driven while reflectometry disabled");

   chk_send_starts: assert property (
      send_req |=> monitor_busy && time_q == TIME_FIRST)
      else $error("send did not start the monitor at time zero");

   chk_source_slow: assert property (
      (send_req && !reg_wdata[CTL_FAST_SRC]) |=> !fast_line_driver_pulse [*8])
      else $error("fast driver used in slow source mode");

   chk_width_seven: assert property (
      (send_req && reg_wdata[CTL_WIDTH_HI:CTL_WIDTH_LO] == 3'h7 && reg_wdata[CTL_FAST_SRC])
      ##1 (reflect_owns_drivers [*7])
      |-> $past(fast_line_driver_pulse, 6) && fast_line_driver_pulse
      ##1 !fast_line_driver_pulse)
      else $error("seven clock pulse has wrong length");

   chk_zero_width: assert property (
      (send_req && reg_wdata[CTL_WIDTH_HI:CTL_WIDTH_LO] == WIDTH_NONE)
      |=> (!slow_line_driver_pulse && !fast_line_driver_pulse) [*5])
      else $error("pulse sent with zero width");

   chk_fast_alternate: assert property (
      (send_req && reg_wdata[CTL_FAST_SRC] && reg_wdata[CTL_WIDTH_HI:CTL_WIDTH_LO] != WIDTH_NONE)
      |=> fast_pulse_negative != $past(fast_pulse_negative))
      else $error("fast pulse polarity did not alternate");

   chk_window_ignore: assert property (
      (monitor_busy && !send_req && (time_q < win_q[15:8] || time_q > win_q[7:0]))
      |=> $stable(peak_val_q) && $stable(thr_time_q))
      else $error("sample outside window changed a result");

   chk_first_time: assert property (
      (thr_seen_q && !send_req) |=> $stable(thr_time_q) && $stable(thr_val_q))
      else $error("threshold time moved after first crossing");

   chk_window_reset: assert property (
      ($past(rst_n) == 1'b0 && !$past(reg_wr)) |-> win_q == WIN_RESET)
      else $error("window not at reset value");

   chk_results_hold: assert property (
      (!monitor_busy && !send_req) |=> $stable(peak_val_q) && $stable(peak_time_q))
      else $error("result changed while idle");

   cov_slow_send: cover property (send_req && !reg_wdata[CTL_FAST_SRC]);
   cov_fast_send: cover property (send_req && reg_wdata[CTL_FAST_SRC]);
   cov_threshold_hit: cover property (monitor_busy ##1 $rose(thr_seen_q));
   cov_run_done: cover property (monitor_busy ##1 !monitor_busy);
endmodule

// ===== common/crc_pkg.sv
// Constants for the cable reflectometry control block
package crc_pkg;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [4:0] ADDR_CONTROL = 5'h16;
   localparam logic [4:0] ADDR_WINDOW = 5'h17;
   localparam logic [4:0] ADDR_PEAK = 5'h18;
   localparam logic [4:0] ADDR_THRESHOLD = 5'h19;
   // ----------------------------------------
   // Control fields
   // ----------------------------------------
   localparam int CTL_ENABLE = 15;
   localparam int CTL_FAST_SRC = 14;
   localparam int CTL_TX_ON_RX = 13;
   localparam int CTL_MON_ON_RX = 12;
   localparam int CTL_SEND = 11;
   localparam int CTL_WIDTH_HI = 10;
   localparam int CTL_WIDTH_LO = 8;
   localparam int CTL_MIN_MODE = 7;
   localparam logic [15:0] CTL_WRITE_MASK = 16'hF780;
   localparam logic [15:0] CTL_RESET = 16'h0000;
   // ----------------------------------------
   // Window and results
   // ----------------------------------------
   localparam logic [15:0] WIN_RESET = 16'h00FF;
   localparam logic [7:0] TIME_LAST = 8'hFF;
   localparam logic [7:0] TIME_FIRST = 8'h00;
   localparam logic [2:0] WIDTH_NONE = 3'h0;
   localparam logic [2:0] WIDTH_ONE = 3'h1;
   localparam logic [7:0] SAMPLE_MOST_NEG = 8'h80;
   localparam logic [7:0] SAMPLE_MOST_POS = 8'h7F;
   localparam int SAMPLE_NS = 8;
   localparam int WINDOW_SPAN_NS = 2048;
   localparam int WINDOW_TICKS = WINDOW_SPAN_NS / SAMPLE_NS;
   typedef enum logic {ST_IDLE, ST_RUN} crc_state_t;
endpackage

// ===== sim/crc_cable_model.sv
// Cable model that plays back programmed reflection samples on each pair
`timescale 1ns/1ps
module crc_cable_model
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic monitor_busy,
   output logic [7:0] adc_tx_pair,
   output logic [7:0] adc_rx_pair
);
   logic [7:0] wave_tx [256];
   logic [7:0] wave_rx [256];
   logic [7:0] idx_q;
   logic idle_q;
   // Sample index follows the monitor time
   always_ff @(posedge clock)
   begin
      if (!rst_n || !monitor_busy)
         idx_q <= 8'h00;
      else
         idx_q <= idx_q + 8'h01;
   end
   // Idle lines keep changing
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         idle_q <= 1'b0;
      else
         idle_q <= !idle_q;
   end
   assign adc_tx_pair = monitor_busy ? wave_tx[idx_q] : ({8{idle_q}} ^ 8'h5A);
   assign adc_rx_pair = monitor_busy ? wave_rx[idx_q] : ({8{idle_q}} ^ 8'hA5);
endmodule

// ===== sim/tb.sv
// Self-checking bench for the reflectometry control block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
   $display("unexpected %s expected %h seen %h", nm, e, g); end end
module tb
   import crc_pkg::*;
;
   logic clock, rst_n, reg_wr, reg_rd, rd_d, exp_neg;
   logic [4:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, pk, thr, ev;
   logic [7:0] adc_tx, adc_rx, threshold_level;
   logic owns, slow, fast, neg, on_rx, busy;
   int n_errors, n_compared, cyc;
   string q_nm[$], nm;
   logic [15:0] q_v[$];
   crc_top DUT (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .adc_tx_pair(adc_tx),
      .adc_rx_pair(adc_rx), .threshold_level(threshold_level), .reflect_owns_drivers(owns),
      .slow_line_driver_pulse(slow), .fast_line_driver_pulse(fast),
      .fast_pulse_negative(neg), .pulse_on_rx_pair(on_rx), .monitor_busy(busy));
   crc_cable_model cable (.clock(clock), .rst_n(rst_n), .monitor_busy(busy),
      .adc_tx_pair(adc_tx), .adc_rx_pair(adc_rx));
   task print_verdict();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [4:0] a, input string n, input logic [15:0] v);
      q_nm.push_back(n);
      q_v.push_back(v);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
   endtask
   // Read results are compared against the oldest note
   always @(posedge clock)
   begin
      if (rd_d === 1'b1)
      begin
         nm = q_nm.pop_front();
         ev = q_v.pop_front();
         `CHK(nm, ev, reg_rdata)
      end
      rd_d <= reg_rd;
      cyc++;
      if (cyc == 6000)
      begin
         n_errors++;
         print_verdict();
      end
   end
   task automatic run(input int i);
      logic f, tr, mr, mn, pg, tg;
      logic [2:0] w;
      logic [7:0] s, e, th, v;
      logic [7:0] src [256];
      int ns, nf, nb;
      f = i[0];
      mn = i[1];
      mr = i[2];
      tr = 1'($urandom);
      w = (i == 0) ? 3'h0 : 3'($urandom_range(7, 1));
      // Window starts past the outgoing pulse on the transmit pair
      s = mr ? 8'($urandom_range(40)) : 8'(w) + 8'($urandom_range(40, 1));
      e = (i == 7) ? s - 8'h01 : 8'($urandom_range(255, s));
      th = 8'($urandom_range(12)) - 8'h06;
      pg = 0;
      tg = 0;
      pk = 16'h0000;
      thr = 16'h0000;
      for (int t = 0; t < 256; t++)
      begin
         cable.wave_tx[t] = 8'($urandom_range(15)) - 8'h08;
         cable.wave_rx[t] = 8'($urandom_range(15)) - 8'h08;
         src[t] = mr ? cable.wave_rx[t] : cable.wave_tx[t];
         v = src[t];
         if (t >= s && t <= e)
         begin
            if (!pg || (mn ? $signed(v) < $signed(pk[7:0]) : $signed(v) > $signed(pk[7:0])))
               pk = {8'(t), v};
            pg = 1;
            if (!tg && (mn ? $signed(v) < $signed(th) : $signed(v) > $signed(th)))
            begin
               thr = {8'(t), v};
               tg = 1;
            end
         end
      end
      threshold_level <= th;
      wr(ADDR_WINDOW, {s, e});
      wr(ADDR_CONTROL, {1'b1, f, tr, mr, 1'b1, w, mn, 7'h00});
      if (f && w != WIDTH_NONE)
         exp_neg = !exp_neg;
      ns = 0;
      nf = 0;
      nb = 0;
      // Levels are looked at mid-cycle, clear of the edge that moves them
      while (nb < 300)
      begin
         @(negedge clock);
         if (busy !== 1'b1)
            break;
         nb++;
         ns += int'(slow === 1'b1);
         nf += int'(fast === 1'b1);
      end
      `CHK("busy", WINDOW_TICKS, nb)
      `CHK("slow", f ? 0 : int'(w), ns)
      `CHK("fast", f ? int'(w) : 0, nf)
      `CHK("neg", exp_neg, neg)
      `CHK("owns", 1'b1, owns)
      `CHK("pair", tr, on_rx)
      rd(ADDR_PEAK, "peak", pk);
      rd(ADDR_THRESHOLD, "thresh", thr);
      repeat (3) @(posedge clock);
      rd(ADDR_PEAK, "peak hold", pk);
   endtask
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   initial
   begin
      rst_n = 1'b0;
      reg_addr = 5'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 16'h0000;
      threshold_level = 8'h00;
      exp_neg = 1'b0;
      void'($urandom(37343));
      repeat (5) @(posedge clock);
      rst_n <= 1'b1;
      rd(ADDR_CONTROL, "control", CTL_RESET);
      rd(ADDR_WINDOW, "window", WIN_RESET);
      rd(ADDR_PEAK, "peak", 16'h0000);
      rd(ADDR_THRESHOLD, "thresh", 16'h0000);
      rd(5'h1A, "unmapped", 16'h0000);
      wr(ADDR_CONTROL, 16'hF5FF);
      rd(ADDR_CONTROL, "control", 16'hF5FF & CTL_WRITE_MASK);
      for (int i = 0; i < 8; i++)
         run(i);
      wr(ADDR_PEAK, 16'hFFFF);
      rd(ADDR_PEAK, "peak ro", pk);
      wr(ADDR_CONTROL, 16'h0B00);
      repeat (3) @(posedge clock);
      `CHK("owns", 1'b0, owns)
      `CHK("busy", 1'b0, busy)
      `CHK("pending", 0, q_v.size())
      print_verdict();
   end
endmodule
